// [hdl/chi_interp_top.sv]
// chi_interp_top: 4:2:2 to 4:4:4 chroma interpolation with optional output rate doubling
//
// How it works
// - received chroma passes unchanged; a filtered sample is inserted between neighbours.
// - wide clamp turns interpolated 0 into 1 and 255 into 254.
// - narrow clamp forces interpolated 0..15 to 16 and 241..255 to 240.
// - long filter is symmetric 12-tap, odd offsets, 160 -48 24 -12 6 -2 over 256.
// - long path keeps 17 signed bits, then rounds to 8 per control setting.
// - short filter averages the two neighbours, 11 bits, then rounds to 8.
// - luma and control are delayed to match chroma; latency independent of filter.
// - long filter falls back to short near line edges until its window is full.
// - last active pixel of a line reuses the previous chroma sample.
// - rate doubling gives a new output value every clock instead of every second.
// - doubler passes originals and inserts neighbour averages, 9 bits, optional dither.
// - two generators: one for matrix and doubler, one for chroma, dither only.
// - matrix generator starts at zero; lane dither bits are adjacent.
// - doubler dithers lanes with generator bits 12, 13 and 14.
// - one chroma generator serves both chroma kinds; it starts at zero.
// - long result has 7 fraction bits, dithered by a 7-bit random value.
// - short chroma filter dithers with generator bit 0 only.
// - blue chroma phase flag is high for a Cb sample, updated while half clock high.
`timescale 1ns/1ps
module chi_interp_top
  import chi_pkg::*;
#(
  parameter int DLY = chi_pkg::CHI_YDLY
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] y_i,
  input wire logic [7:0] crcb_i,
  input wire logic active_i,
  input wire logic h_i,
  input wire logic v_i,
  input wire logic f_i,
  output logic half_clk_o,
  output logic blue_chroma_phase_flag_o,
  output logic [7:0] y_o,
  output logic [7:0] cb_o,
  output logic [7:0] cr_o,
  output logic active_o,
  output logic h_o,
  output logic v_o,
  output logic f_o
);
  import chi_pkg::*;

  if (DLY < 2) begin : g_chk
    $error("chi_interp_top: delay must be at least 2");
  end

  chi_ctl_if ctl ();
  chi_rng_if #(.W(CHI_RNG_C_W)) rng_c ();
  chi_rng_if #(.W(CHI_RNG_M_W)) rng_m ();

  // ****************************************
  // register slave and generators
  // ****************************************
  chi_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .ctl(ctl)
  );

  // one chroma generator, time-shared between both kinds
  chi_lfsr #(.W(CHI_RNG_C_W), .TAPS(CHI_RNG_C_TAPS), .RST(CHI_RNG_C_RST)) u_rng_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rng(rng_c)
  );

  // matrix and doubler generator, zero after reset
  chi_lfsr #(.W(CHI_RNG_M_W), .TAPS(CHI_RNG_M_TAPS), .RST(CHI_RNG_M_RST)) u_rng_m (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rng(rng_m)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [19:0] sy1_r, sy2_r;
  logic [3:0] in_ctl; // {f, v, h, active}
  logic [7:0] in_y, in_c;

  // two flops before anything looks at a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_r <= 20'h00000;
      sy2_r <= 20'h00000;
    end else begin
      sy1_r <= {f_i, v_i, h_i, active_i, y_i, crcb_i};
      sy2_r <= sy1_r;
    end
  end

  assign in_ctl = sy2_r[19:16];
  assign in_y = sy2_r[15:8];
  assign in_c = sy2_r[7:0];

  // ****************************************
  // sample phase and chroma kind
  // ****************************************
  logic phase_r, phase_nxt;
  logic kind_cb_r, kind_cb_nxt;
  logic act_prev_r, act_prev_nxt;
  logic strobe, cur_cb;

  assign strobe = phase_r; // samples taken while the half clock is high
  assign cur_cb = (in_ctl[0] & ~act_prev_r) ? 1'b1 : kind_cb_r; // line start is Cb

  // half clock toggles; kind alternates on each taken sample
  always_comb begin
    phase_nxt = ~phase_r;
    kind_cb_nxt = kind_cb_r;
    act_prev_nxt = act_prev_r;
    if (strobe) begin
      kind_cb_nxt = ~cur_cb;
      act_prev_nxt = in_ctl[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
      kind_cb_r <= 1'b1;
      act_prev_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      kind_cb_r <= kind_cb_nxt;
      act_prev_r <= act_prev_nxt;
    end
  end

  // ****************************************
  // chroma windows and luma/control delay
  // ****************************************
  logic [7:0] cbw_r [0:CHI_TAPS-1];
  logic [7:0] crw_r [0:CHI_TAPS-1];
  logic [7:0] cbw_nxt [0:CHI_TAPS-1];
  logic [7:0] crw_nxt [0:CHI_TAPS-1];
  logic [CHI_TAPS-1:0] cbv_r, crv_r, cbv_nxt, crv_nxt;
  logic [11:0] ydl_r [0:DLY-1];
  logic [11:0] ydl_nxt [0:DLY-1];
  logic calc_r, calc_nxt, calc_cb_r, calc_cb_nxt;

  // each kind shifts its own window; luma and control follow every sample
  always_comb begin
    cbv_nxt = cbv_r;
    crv_nxt = crv_r;
    for (int k = 0; k < CHI_TAPS; k++) begin
      cbw_nxt[k] = cbw_r[k];
      crw_nxt[k] = crw_r[k];
    end
    for (int k = 0; k < DLY; k++) begin
      ydl_nxt[k] = ydl_r[k];
    end
    calc_nxt = strobe;
    calc_cb_nxt = cur_cb;
    if (strobe) begin
      ydl_nxt[0] = {in_ctl, in_y};
      for (int k = 1; k < DLY; k++) begin
        ydl_nxt[k] = ydl_r[k-1];
      end
      if (cur_cb) begin
        cbw_nxt[0] = in_c;
        cbv_nxt = {cbv_r[CHI_TAPS-2:0], in_ctl[0]};
        for (int k = 1; k < CHI_TAPS; k++) begin
          cbw_nxt[k] = cbw_r[k-1];
        end
      end else begin
        crw_nxt[0] = in_c;
        crv_nxt = {crv_r[CHI_TAPS-2:0], in_ctl[0]};
        for (int k = 1; k < CHI_TAPS; k++) begin
          crw_nxt[k] = crw_r[k-1];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cbv_r <= '0;
      crv_r <= '0;
      calc_r <= 1'b0;
      calc_cb_r <= 1'b0;
      for (int k = 0; k < CHI_TAPS; k++) begin
        cbw_r[k] <= 8'h00;
        crw_r[k] <= 8'h00;
      end
      for (int k = 0; k < DLY; k++) begin
        ydl_r[k] <= 12'h000;
      end
    end else begin
      cbv_r <= cbv_nxt;
      crv_r <= crv_nxt;
      calc_r <= calc_nxt;
      calc_cb_r <= calc_cb_nxt;
      cbw_r <= cbw_nxt;
      crw_r <= crw_nxt;
      ydl_r <= ydl_nxt;
    end
  end

  // ****************************************
  // interpolation filter, shared by both kinds
  // ****************************************
  logic [7:0] w [0:CHI_TAPS-1];
  logic [CHI_TAPS-1:0] wv;
  logic signed [17:0] acc, term, pr;
  logic [10:0] sum2;
  logic [7:0] res_long, res_short, interp;
  logic use_long;

  // window centre sits between taps 6 (older) and 5 (newer)
  always_comb begin
    acc = 18'sh00000;
    term = 18'sh00000;
    pr = 18'sh00000;
    wv = calc_cb_r ? cbv_r : crv_r;
    for (int k = 0; k < CHI_TAPS; k++) begin
      w[k] = calc_cb_r ? cbw_r[k] : crw_r[k];
    end
    for (int k = 0; k < 6; k++) begin
      term = 18'(CHI_COEF[k]);
      pr = {10'h000, w[5-k]} + {10'h000, w[6+k]};
      acc = acc + term * pr;
    end
    sum2 = {3'h0, w[5]} + {3'h0, w[6]};
    // coefficients are even, so the dropped bit is always zero
    res_long = chi_clamp(chi_round(acc[17:1], CHI_FRAC_LONG, ctl.rnd_en ? rng_c.bits : CHI_HALF_LONG),
                         ctl.clamp_range_select);
    res_short = chi_clamp(chi_round({6'h00, sum2}, CHI_FRAC_SHORT,
                                    ctl.rnd_en ? {6'h00, rng_c.bits[0]} : CHI_HALF_SHORT),
                          ctl.clamp_range_select);
    use_long = ctl.long_sel & (&wv); // short filter until the window is full
    interp = use_long ? res_long : res_short;
    if (!wv[5]) begin
      interp = w[6]; // last active pixel repeats previous chroma
    end
  end

  assign rng_c.step = calc_r & ctl.rnd_en & wv[5]; // one step per dithered sample

  // ****************************************
  // chroma results, pair hold and pixel assembly
  // ****************************************
  logic [7:0] cbo_r, cbi_r, cro_r, cri_r, pcbi_r, pcri_r;
  logic [7:0] cbo_nxt, cbi_nxt, cro_nxt, cri_nxt, pcbi_nxt, pcri_nxt;
  logic [2:0][7:0] pix_r, pix_nxt; // lanes: cr, y, cb
  logic [3:0] pctl_r, pctl_nxt;
  logic long_used_r, long_used_nxt;

  // originals pass untouched, interpolated value fills the odd pixel
  always_comb begin
    cbo_nxt = cbo_r;
    cbi_nxt = cbi_r;
    cro_nxt = cro_r;
    cri_nxt = cri_r;
    pcbi_nxt = pcbi_r;
    pcri_nxt = pcri_r;
    pix_nxt = pix_r;
    pctl_nxt = pctl_r;
    long_used_nxt = long_used_r;
    if (calc_r) begin
      long_used_nxt = use_long;
      if (calc_cb_r) begin
        cbo_nxt = w[6];
        cbi_nxt = interp;
      end else begin
        cro_nxt = w[6];
        cri_nxt = interp;
      end
    end
    if (strobe) begin
      pctl_nxt = ydl_r[DLY-1][11:8];
      if (cur_cb) begin
        pcbi_nxt = cbi_r;
        pcri_nxt = cri_r;
        pix_nxt = {cbo_r, ydl_r[DLY-1][7:0], cro_r};
      end else begin
        pix_nxt = {pcbi_r, ydl_r[DLY-1][7:0], pcri_r};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cbo_r <= 8'h00;
      cbi_r <= 8'h00;
      cro_r <= 8'h00;
      cri_r <= 8'h00;
      pcbi_r <= 8'h00;
      pcri_r <= 8'h00;
      pix_r <= '0;
      pctl_r <= 4'h0;
      long_used_r <= 1'b0;
    end else begin
      cbo_r <= cbo_nxt;
      cbi_r <= cbi_nxt;
      cro_r <= cro_nxt;
      cri_r <= cri_nxt;
      pcbi_r <= pcbi_nxt;
      pcri_r <= pcri_nxt;
      pix_r <= pix_nxt;
      pctl_r <= pctl_nxt;
      long_used_r <= long_used_nxt;
    end
  end

  // ****************************************
  // output stage with rate doubler
  // ****************************************
  logic [2:0][7:0] out_r, out_nxt;
  logic [3:0] octl_r, octl_nxt;

  // original on the taken edge, neighbour average on the other edge
  for (genvar i = 0; i < CHI_LANES; i++) begin : g_lane
    logic [8:0] lsum;
    always_comb begin
      lsum = {1'b0, out_r[i]} + {1'b0, pix_r[i]};
      out_nxt[i] = out_r[i];
      if (strobe) begin
        out_nxt[i] = pix_r[i];
      end else if (ctl.dbl_en) begin
        out_nxt[i] = chi_round({8'h00, lsum}, CHI_FRAC_SHORT,
                               ctl.rnd_en ? {6'h00, rng_m.bits[CHI_RNG_M_DBL_BIT+i]} : CHI_HALF_SHORT);
      end
    end
  end

  assign octl_nxt = strobe ? pctl_r : octl_r;
  assign rng_m.step = ~strobe & ctl.dbl_en & ctl.rnd_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r <= '0;
      octl_r <= 4'h0;
    end else begin
      out_r <= out_nxt;
      octl_r <= octl_nxt;
    end
  end

  // ****************************************
  // outputs and status
  // ****************************************
  assign cr_o = out_r[0];
  assign y_o = out_r[1];
  assign cb_o = out_r[2];
  assign {f_o, v_o, h_o, active_o} = octl_r;
  assign half_clk_o = phase_r;
  assign blue_chroma_phase_flag_o = kind_cb_r;
  assign ctl.status = {long_used_r, act_prev_r, phase_r, kind_cb_r};
endmodule

// [hdl/chi_pkg.sv]
// chi_pkg: constants, register map and rounding helpers for the chroma interpolator
package chi_pkg;
  // ****************************************
  // stream geometry
  // ****************************************
  localparam int CHI_TAPS = 12; // long filter window length
  localparam int CHI_YDLY = 14; // luma/control delay in samples
  localparam int CHI_LANES = 3;
  // long filter coefficients in 1/256, outermost last: 160 -48 24 -12 6 -2
  localparam logic signed [8:0] CHI_COEF [0:5] = '{9'h0A0, 9'h1D0, 9'h018, 9'h1F4, 9'h006, 9'h1FE};
  localparam logic [2:0] CHI_FRAC_LONG = 3'h7;
  localparam logic [2:0] CHI_FRAC_SHORT = 3'h1;
  localparam logic [6:0] CHI_HALF_LONG = 7'h40;
  localparam logic [6:0] CHI_HALF_SHORT = 7'h01;
  // ****************************************
  // clamp limits
  // ****************************************
  localparam logic [7:0] CHI_LO_NARROW = 8'h10;
  localparam logic [7:0] CHI_HI_NARROW = 8'hF0;
  localparam logic [7:0] CHI_LO_WIDE = 8'h01;
  localparam logic [7:0] CHI_HI_WIDE = 8'hFE;
  // ****************************************
  // dither generators
  // ****************************************
  localparam int CHI_RNG_M_W = 15;
  localparam int CHI_RNG_C_W = 7;
  localparam logic [14:0] CHI_RNG_M_TAPS = 15'h6000;
  localparam logic [6:0] CHI_RNG_C_TAPS = 7'h60;
  localparam logic [14:0] CHI_RNG_M_RST = 15'h0000;
  localparam logic [6:0] CHI_RNG_C_RST = 7'h00;
  localparam int CHI_RNG_M_DBL_BIT = 12; // red lane, green and blue follow
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CHI_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CHI_ADDR_STAT = 8'h04;
  localparam int CHI_CTL_CLAMP_BIT = 0;
  localparam int CHI_CTL_LONG_BIT = 1;
  localparam int CHI_CTL_DBL_BIT = 2;
  localparam int CHI_CTL_RND_BIT = 3;
  localparam logic [3:0] CHI_CTRL_RST = 4'h2;

  // round a signed fixed-point value to 8 bits and saturate to 0..255
  function automatic logic [7:0] chi_round(input logic signed [16:0] v, input logic [2:0] frac,
                                           input logic [6:0] add);
    logic signed [17:0] s;
    s = {v[16], v} + {11'h000, add};
    s = s >>> frac;
    if (s < 18'sh00000) begin
      return 8'h00;
    end else if (s > 18'sh000FF) begin
      return 8'hFF;
    end
    return s[7:0];
  endfunction

  // limit an interpolated chroma value to the selected range
  function automatic logic [7:0] chi_clamp(input logic [7:0] v, input logic wide);
    if (wide) begin
      if (v < CHI_LO_WIDE) return CHI_LO_WIDE;
      if (v > CHI_HI_WIDE) return CHI_HI_WIDE;
    end else begin
      if (v < CHI_LO_NARROW) return CHI_LO_NARROW;
      if (v > CHI_HI_NARROW) return CHI_HI_NARROW;
    end
    return v;
  endfunction
endpackage

// [hdl/chi_if.sv]
// chi_if: internal carriers for dither generators and control settings
`timescale 1ns/1ps
interface chi_rng_if #(parameter int W = 7);
  logic step;
  logic [W-1:0] bits;
  modport gen(input step, output bits);
  modport user(output step, input bits);
endinterface

interface chi_ctl_if;
  logic clamp_range_select;
  logic long_sel;
  logic dbl_en;
  logic rnd_en;
  logic [3:0] status;
  modport regs(output clamp_range_select, long_sel, dbl_en, rnd_en, input status);
  modport core(input clamp_range_select, long_sel, dbl_en, rnd_en, output status);
endinterface

// [hdl/chi_lfsr.sv]
// chi_lfsr: xnor-feedback pseudo-random generator, all-zero start state
`timescale 1ns/1ps
module chi_lfsr #(
  parameter int W = 7,
  parameter logic [W-1:0] TAPS = '0,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  chi_rng_if.gen rng
);
  logic [W-1:0] state_r;
  logic [W-1:0] state_nxt;

  if (W < 2) begin : g_chk
    $error("chi_lfsr: width must be at least 2");
  end

  // shift one step per request; xnor keeps zero a legal state
  always_comb begin
    state_nxt = state_r;
    if (rng.step) begin
      state_nxt = {state_r[W-2:0], ~^(state_r & TAPS)};
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rng.bits = state_r;
endmodule

// [hdl/chi_wb_regs.sv]
// chi_wb_regs: classic wishbone slave holding control and status
`timescale 1ns/1ps
module chi_wb_regs
  import chi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  chi_ctl_if.regs ctl
);
  logic [3:0] ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;

  // decode, write on the answering edge, read data captured with ack
  always_comb begin
    ctrl_nxt = ctrl_r;
    dat_nxt = dat_r;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    if (ack_nxt) begin
      dat_nxt = 32'h00000000; // unmapped reads as zero
      if (wb_adr_i == CHI_ADDR_CTRL) begin
        dat_nxt = {28'h0000000, ctrl_r};
        if (wb_we_i && wb_sel_i[0]) begin
          ctrl_nxt = wb_dat_i[3:0];
        end
      end else if (wb_adr_i == CHI_ADDR_STAT) begin
        dat_nxt = {28'h0000000, ctl.status};
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CHI_CTRL_RST;
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign ctl.clamp_range_select = ctrl_r[CHI_CTL_CLAMP_BIT];
  assign ctl.long_sel = ctrl_r[CHI_CTL_LONG_BIT];
  assign ctl.dbl_en = ctrl_r[CHI_CTL_DBL_BIT];
  assign ctl.rnd_en = ctrl_r[CHI_CTL_RND_BIT];
endmodule

// [bench/chi_src_model.sv]
// chi_src_model: upstream 4:2:2 source, one sample held for two clocks
`timescale 1ns/1ps
module chi_src_model (
  input wire logic clk_i,
  input wire logic half_clk_i,
  input wire logic go_i,
  output logic [7:0] y_o,
  output logic [7:0] crcb_o,
  output logic active_o,
  output logic h_o,
  output logic f_o,
  output logic busy_o
);
  localparam int NPIX = 32;
  localparam int NBLK = 24;
  localparam int TOTAL = 2 * NBLK + NPIX;
  logic [7:0] yv [0:NPIX-1];
  logic [7:0] cv [0:NPIX-1];
  int idx = 0;
  initial begin
    y_o = 8'h00;
    crcb_o = 8'h5A;
    active_o = 1'b0;
    h_o = 1'b1;
    f_o = 1'b0;
    busy_o = 1'b0;
  end
  // new sample right after the edge where the half clock rises; blanking data flips every sample
  always @(posedge clk_i) begin
    int pos;
    if (!half_clk_i && (busy_o || go_i)) begin
      pos = busy_o ? idx + 1 : 0;
      busy_o <= (pos < TOTAL);
      idx <= pos;
      if (pos == TOTAL) f_o <= ~f_o;
      active_o <= (pos >= NBLK) && (pos < NBLK + NPIX);
      h_o <= !((pos >= NBLK) && (pos < NBLK + NPIX));
      if ((pos >= NBLK) && (pos < NBLK + NPIX)) begin
        y_o <= yv[pos-NBLK];
        crcb_o <= cv[pos-NBLK]; // Cb first, then Cr
      end else begin
        y_o <= ~y_o;
        crcb_o <= ~crcb_o;
      end
    end
  end
endmodule

// [bench/chi_interp_checker.sv]
// chi_interp_checker: port-level assertions for the chroma interpolator
`timescale 1ns/1ps
module chi_interp_checker
  import chi_pkg::*;
#(
  parameter int DLY = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic half_clk_o,
  input logic blue_chroma_phase_flag_o,
  input logic active_o,
  input logic h_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // assertions
  // ****************************************
  half_toggle_a: assert property (1'b1 |=> half_clk_o != $past(half_clk_o)) else $error("half clock stuck");
  flag_phase_a: assert property ($changed(blue_chroma_phase_flag_o) |-> $past(half_clk_o))
    else $error("phase flag moved in low half");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:4] == 28'h0) else $error("upper read bits set");
  unmapped_zero_a: assert property (wb_ack_o && $past(wb_adr_i) != CHI_ADDR_CTRL && $past(wb_adr_i) != CHI_ADDR_STAT
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  ctl_hold_a: assert property ($changed({active_o, h_o}) |=> $stable({active_o, h_o}))
    else $error("controls changed on consecutive edges");
  // main scenarios
  write_c: cover property (wb_ack_o && $past(wb_we_i));
  line_c: cover property ($rose(active_o));
  flag_c: cover property ($fell(blue_chroma_phase_flag_o));
endmodule
bind chi_interp_top chi_interp_checker #(.DLY(DLY)) u_chi_interp_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .half_clk_o(half_clk_o), .blue_chroma_phase_flag_o(blue_chroma_phase_flag_o),
  .active_o(active_o), .h_o(h_o));

// [bench/testbench.sv]
// testbench: self-checking bench for the chroma interpolator
`timescale 1ns/1ps
module testbench;
  import chi_pkg::*;
  localparam int NPIX = 32;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, go = 0, vin = 0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, half_clk_o, flag_o, active_o, h_o, v_o, f_o, s_act, s_h, s_f, s_busy;
  logic [7:0] y_o, cb_o, cr_o, s_y, s_c;
  logic [15:0] lfsr = 16'h0015;
  int errors = 0;
  int n_tests = 0;
  int lat_ref = -1;
  int lines = 0;
  chi_interp_top #(.DLY(14)) u_chi_interp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .y_i(s_y), .crcb_i(s_c), .active_i(s_act), .h_i(s_h),
    .v_i(vin), .f_i(s_f), .half_clk_o(half_clk_o), .blue_chroma_phase_flag_o(flag_o), .y_o(y_o),
    .cb_o(cb_o), .cr_o(cr_o), .active_o(active_o), .h_o(h_o), .v_o(v_o), .f_o(f_o));
  chi_src_model u_chi_src_model (.clk_i(clk_i), .half_clk_i(half_clk_o), .go_i(go), .y_o(s_y), .crcb_o(s_c),
    .active_o(s_act), .h_o(s_h), .f_o(s_f), .busy_o(s_busy));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  // neighbour average, up selects half-up rounding
  function automatic logic [7:0] avg(input logic [7:0] a, input logic [7:0] b, input logic up);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b} + {8'h00, up};
    return s[8:1];
  endfunction
  function automatic logic [7:0] lim(input logic [7:0] v, input logic wide);
    if (wide) return (v == 8'h00) ? 8'h01 : (v == 8'hFF) ? 8'hFE : v;
    return (v < 8'h10) ? 8'h10 : (v > 8'hF0) ? 8'hF0 : v;
  endfunction
  // long filter reference in 1/256 steps: bias 128 rounds half up, 0 and 254 bound a dithered result
  function automatic logic [7:0] lng(input logic [7:0] c [0:NPIX-1], input int q, input int bias,
                                     input logic wide);
    int s;
    s = bias;
    for (int t = 0; t < 6; t++) begin
      s += int'(CHI_COEF[t]) * (int'(c[q-2*t]) + int'(c[q+2+2*t]));
    end
    s = s >>> 8;
    return lim((s < 0) ? 8'h00 : (s > 255) ? 8'hFF : 8'(s), wide);
  endfunction
  task automatic cmp(input string name, input logic [31:0] ea, input logic [31:0] eb, input logic [31:0] got);
    n_tests++;
    if (got !== ea && got !== eb) begin
      errors++;
      $display("Error %s expected %h seen %h", name, ea, got);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang_if(input int n);
    if (n >= 400) begin
      errors++;
      complete_run();
    end
  endtask
  // classic wishbone cycle, entered right after a rising edge
  task automatic wb(input logic [7:0] adr, input logic we, input logic [3:0] sel, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 400);
    hang_if(n);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // ****************************************
  // one line through the pipeline
  // ****************************************
  task automatic run_line(input logic [3:0] ctl);
    logic [7:0] ey [0:NPIX-1];
    logic [7:0] eh [0:1][0:NPIX-1];
    logic [7:0] el [0:1][0:NPIX-1];
    logic [7:0] c [0:NPIX-1];
    logic [31:0] rd;
    int n, p, k;
    logic dith;
    dith = ctl[3];
    for (int j = 0; j < NPIX; j++) begin
      ey[j] = rnd8();
      c[j] = (j == 0 || j == 2) ? 8'h00 : (j == 5 || j == 7) ? 8'hFF : rnd8();
      u_chi_src_model.yv[j] = ey[j];
      u_chi_src_model.cv[j] = c[j];
    end
    for (int j = 0; j < NPIX; j++) begin
      p = 2 * (j / 2);
      for (k = 0; k < 2; k++) begin
        if (j % 2 == 0 || j == NPIX - 1) begin
          eh[k][j] = c[p+k];
          el[k][j] = c[p+k];
        end else if (ctl[1] && p >= 10 && p <= NPIX - 14) begin
          eh[k][j] = lng(c, p + k, dith ? 254 : 128, ctl[0]);
          el[k][j] = lng(c, p + k, dith ? 0 : 128, ctl[0]);
        end else begin
          eh[k][j] = lim(avg(c[p+k], c[p+k+2], 1'b1), ctl[0]);
          el[k][j] = lim(avg(c[p+k], c[p+k+2], !dith), ctl[0]);
        end
      end
    end
    wb(CHI_ADDR_CTRL, 1'b1, 4'h1, {28'h0, ctl}, rd);
    vin <= ey[1][0];
    go <= 1'b1;
    n = 0;
    while (s_busy !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    hang_if(n);
    go <= 1'b0;
    n = 0;
    while (s_act !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    hang_if(n);
    n = 0;
    while (active_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    hang_if(n);
    if (lat_ref < 0) lat_ref = n;
    cmp("latency", lat_ref, lat_ref, n);
    for (int j = 0; j < NPIX; j++) begin
      cmp("y_o", ey[j], ey[j], y_o);
      cmp("cb_o", eh[0][j], el[0][j], cb_o);
      cmp("cr_o", eh[1][j], el[1][j], cr_o);
      cmp("ctl_o", {lines[0], vin, 2'b01}, {lines[0], vin, 2'b01}, {f_o, v_o, h_o, active_o});
      @(posedge clk_i);
      if (ctl[2] && j < NPIX - 1) begin
        cmp("y_o dbl", avg(ey[j], ey[j+1], 1'b1), avg(ey[j], ey[j+1], !dith), y_o);
        if (!dith) cmp("cb_o dbl", avg(eh[0][j], eh[0][j+1], 1'b1), avg(eh[0][j], eh[0][j+1], 1'b1), cb_o);
        if (!dith) cmp("cr_o dbl", avg(eh[1][j], eh[1][j+1], 1'b1), avg(eh[1][j], eh[1][j+1], 1'b1), cr_o);
      end else if (!ctl[2]) begin
        cmp("y_o hold", ey[j], ey[j], y_o);
      end
      @(posedge clk_i);
    end
    n = 0;
    while (s_busy !== 1'b0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    hang_if(n);
    lines++;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] rd;
    logic [3:0] modes [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hE, 4'h6};
    repeat (10) @(posedge clk_i);
    cmp("y_o rst", 0, 0, y_o);
    cmp("flag rst", 1, 1, flag_o);
    cmp("half rst", 0, 0, half_clk_o);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(CHI_ADDR_CTRL, 1'b0, 4'hF, 32'h0, rd);
    cmp("ctrl rst", {28'h0, CHI_CTRL_RST}, {28'h0, CHI_CTRL_RST}, rd);
    wb(CHI_ADDR_CTRL, 1'b1, 4'h2, 32'hF, rd);
    wb(8'h08, 1'b1, 4'hF, 32'hF, rd);
    wb(8'h08, 1'b0, 4'hF, 32'h0, rd);
    cmp("unmapped", 0, 0, rd);
    wb(CHI_ADDR_CTRL, 1'b0, 4'hF, 32'h0, rd);
    cmp("ctrl kept", {28'h0, CHI_CTRL_RST}, {28'h0, CHI_CTRL_RST}, rd);
    wb(CHI_ADDR_CTRL, 1'b1, 4'h1, 32'h5, rd);
    wb(CHI_ADDR_CTRL, 1'b0, 4'hF, 32'h0, rd);
    cmp("ctrl wr", 5, 5, rd);
    for (int m = 0; m < 8; m++) run_line(modes[m]);
    complete_run();
  end
endmodule
